// >>> core/bst_pkg.sv
package bst_pkg;

   // instruction codes
   localparam logic [3:0] INSTR_EXTEST     = 4'h0;
   localparam logic [3:0] INSTR_IDCODE     = 4'h1;
   localparam logic [3:0] INSTR_SAMPLE     = 4'h2;
   localparam logic [3:0] INSTR_CHIP_RESET = 4'hC;
   localparam logic [3:0] INSTR_BYPASS     = 4'hF;
   localparam logic [3:0] IR_CAPTURE_VALUE = 4'h1;

   // identification fields, values arbitrary
   localparam logic [3:0]  ID_VERSION      = 4'h0;
   localparam logic [15:0] ID_PART_NUMBER  = 16'h5A5A;
   localparam logic [10:0] ID_MANUFACTURER = 11'h123;

   // boundary chain shape: four cells per pin
   localparam int PIN_COUNT   = 8;
   localparam int CELLS       = 4;
   localparam int CHAIN_LEN   = PIN_COUNT * CELLS;
   localparam int CELL_IN     = 0;
   localparam int CELL_OUT    = 1;
   localparam int CELL_CTRL   = 2;
   localparam int CELL_PULLUP = 3;

   // bus register map
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_IDCODE  = 8'h08;
   localparam int CTRL_DISABLE_BIT    = 0;
   localparam logic CTRL_DISABLE_RESET = 1'b0;
   localparam int STAT_STATE_LSB      = 0;
   localparam int STAT_INSTR_LSB      = 16;
   localparam int STAT_ENABLED_BIT    = 20;
   localparam int STAT_CHIP_RESET_BIT = 21;
   localparam int STAT_EXTEST_BIT     = 22;

   // reset time-out after release, chosen by the clock-option fuse
   localparam int CLOCK_PERIOD_NS      = 25;
   localparam int TIMEOUT_SHORT_NS     = 1000;
   localparam int TIMEOUT_LONG_NS      = 64000;
   localparam int TIMEOUT_SHORT_CYCLES = (TIMEOUT_SHORT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int TIMEOUT_LONG_CYCLES  = (TIMEOUT_LONG_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int TIMEOUT_WIDTH        = 12;

   typedef enum logic [15:0] {
      TAP_RESET      = 16'h0001,
      TAP_IDLE       = 16'h0002,
      TAP_SELECT_DR  = 16'h0004,
      TAP_CAPTURE_DR = 16'h0008,
      TAP_SHIFT_DR   = 16'h0010,
      TAP_EXIT1_DR   = 16'h0020,
      TAP_PAUSE_DR   = 16'h0040,
      TAP_EXIT2_DR   = 16'h0080,
      TAP_UPDATE_DR  = 16'h0100,
      TAP_SELECT_IR  = 16'h0200,
      TAP_CAPTURE_IR = 16'h0400,
      TAP_SHIFT_IR   = 16'h0800,
      TAP_EXIT1_IR   = 16'h1000,
      TAP_PAUSE_IR   = 16'h2000,
      TAP_EXIT2_IR   = 16'h4000,
      TAP_UPDATE_IR  = 16'h8000
   } bst_state_type;

   typedef struct packed {
      logic [PIN_COUNT-1:0] pullupDisable;
      logic [PIN_COUNT-1:0] outCtrl;
      logic [PIN_COUNT-1:0] outData;
   } bst_pins_type;

endpackage : bst_pkg

// >>> core/bst_tap.sv
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps

module bst_tap
   import bst_pkg::*;
(
   // system
   input  wire  logic                  clock,
   input  wire  logic                  reset,
   // ahb-lite slave
   input  wire  logic                  hsel,
   input  wire  logic [31:0]           haddr,
   input  wire  logic [1:0]            htrans,
   input  wire  logic                  hwrite,
   input  wire  logic [2:0]            hsize,
   input  wire  logic [31:0]           hwdata,
   input  wire  logic                  hready,
   output logic       [31:0]           hrdata,
   output logic                        hreadyout,
   output logic                        hresp,
   // test access port
   input  wire  logic                  tck,
   input  wire  logic                  tms,
   input  wire  logic                  tdi,
   output logic                        tdo,
   output logic                        tdoEnable,
   // fuses and external reset
   input  wire  logic                  testPortEnableFuse,
   input  wire  logic                  clockOptionFuse,
   input  wire  logic                  externalReset_n,
   // core side of the pins
   input  wire  bst_pins_type          corePins,
   output logic                        chipReset,
   // package pins
   input  wire  logic [PIN_COUNT-1:0]  pinIn,
   output bst_pins_type                pinDrive
);

   // synchronisers: first stage feeds only the second
   logic [4:0]           syncA;
   logic [4:0]           syncB;
   logic [PIN_COUNT-1:0] pinSyncA;
   logic [PIN_COUNT-1:0] pinSyncB;
   logic                 tckDelay;

   always_ff @(posedge clock) begin
      syncA    <= {testPortEnableFuse, externalReset_n, tdi, tms, tck};
      syncB    <= syncA;
      pinSyncA <= pinIn;
      pinSyncB <= pinSyncA;
      tckDelay <= syncB[0];
   end

   wire tckS      = syncB[0];
   wire tmsS      = syncB[1];
   wire tdiS      = syncB[2];
   wire extResetS = ~syncB[3];
   wire fuseS     = syncB[4];
   // the system clock oversamples tck; any tck below 20 MHz is seen
   wire tckRise   = tckS & ~tckDelay;
   wire tckFall   = ~tckS & tckDelay;

   // bus registers
   logic          disableBit;
   logic          busWrite;
   logic [7:0]    busAddr;

   wire portEnabled = fuseS & ~disableBit;

   // controller
   bst_state_type state;
   bst_state_type next_state;

   always_comb begin
      case (state)
         TAP_RESET:      next_state = tmsS ? TAP_RESET     : TAP_IDLE;
         TAP_IDLE:       next_state = tmsS ? TAP_SELECT_DR : TAP_IDLE;
         TAP_SELECT_DR:  next_state = tmsS ? TAP_SELECT_IR : TAP_CAPTURE_DR;
         TAP_CAPTURE_DR: next_state = tmsS ? TAP_EXIT1_DR  : TAP_SHIFT_DR;
         TAP_SHIFT_DR:   next_state = tmsS ? TAP_EXIT1_DR  : TAP_SHIFT_DR;
         TAP_EXIT1_DR:   next_state = tmsS ? TAP_UPDATE_DR : TAP_PAUSE_DR;
         TAP_PAUSE_DR:   next_state = tmsS ? TAP_EXIT2_DR  : TAP_PAUSE_DR;
         TAP_EXIT2_DR:   next_state = tmsS ? TAP_UPDATE_DR : TAP_SHIFT_DR;
         TAP_UPDATE_DR:  next_state = tmsS ? TAP_SELECT_DR : TAP_IDLE;
         TAP_SELECT_IR:  next_state = tmsS ? TAP_RESET     : TAP_CAPTURE_IR;
         TAP_CAPTURE_IR: next_state = tmsS ? TAP_EXIT1_IR  : TAP_SHIFT_IR;
         TAP_SHIFT_IR:   next_state = tmsS ? TAP_EXIT1_IR  : TAP_SHIFT_IR;
         TAP_EXIT1_IR:   next_state = tmsS ? TAP_UPDATE_IR : TAP_PAUSE_IR;
         TAP_PAUSE_IR:   next_state = tmsS ? TAP_EXIT2_IR  : TAP_PAUSE_IR;
         TAP_EXIT2_IR:   next_state = tmsS ? TAP_UPDATE_IR : TAP_SHIFT_IR;
         TAP_UPDATE_IR:  next_state = tmsS ? TAP_SELECT_DR : TAP_IDLE;
         default:        next_state = TAP_RESET;
      endcase
   end

   // a disabled port is parked in reset
   always_ff @(posedge clock) begin
      if (reset || !portEnabled) begin
         state <= TAP_RESET;
      end else if (tckRise) begin
         state <= next_state;
      end
   end

   // instruction register
   logic [3:0] irShift;
   logic [3:0] instr;

   wire inShiftIr = state == TAP_SHIFT_IR;
   wire inShiftDr = state == TAP_SHIFT_DR;
   wire inCapDr   = state == TAP_CAPTURE_DR;
   wire inUpdDr   = state == TAP_UPDATE_DR;

   always_ff @(posedge clock) begin
      if (reset || state == TAP_RESET) begin
         irShift <= IR_CAPTURE_VALUE;
         instr   <= INSTR_IDCODE;
      end else if (tckRise) begin
         if (state == TAP_CAPTURE_IR) begin
            irShift <= IR_CAPTURE_VALUE;
         end else if (inShiftIr) begin
            irShift <= {tdiS, irShift[3:1]};
         end else if (state == TAP_UPDATE_IR) begin
            instr <= irShift;
         end
      end
   end

   // data register selection; private and unused codes fall to bypass
   wire selExtest   = instr == INSTR_EXTEST;
   wire selSample   = instr == INSTR_SAMPLE;
   wire selChain    = selExtest | selSample;
   wire selId       = instr == INSTR_IDCODE;
   wire selReset    = instr == INSTR_CHIP_RESET;
   wire selBypass   = ~(selChain | selId | selReset);

   // identification register
   wire [31:0] idValue = {ID_VERSION, ID_PART_NUMBER, ID_MANUFACTURER, 1'b1};
   logic [31:0] idShift;

   always_ff @(posedge clock) begin
      if (reset) begin
         idShift <= '0;
      end else if (tckRise && selId) begin
         if (inCapDr) begin
            idShift <= idValue;
         end else if (inShiftDr) begin
            idShift <= {tdiS, idShift[31:1]};
         end
      end
   end

   // bypass register
   logic bypassBit;

   always_ff @(posedge clock) begin
      if (reset) begin
         bypassBit <= 1'b0;
      end else if (tckRise && selBypass) begin
         if (inCapDr) begin
            bypassBit <= 1'b0;
         end else if (inShiftDr) begin
            bypassBit <= tdiS;
         end
      end
   end

   // reset register: unlatched, so it bites mid-shift; the TAP keeps running
   logic resetBit;

   always_ff @(posedge clock) begin
      if (reset || state == TAP_RESET) begin
         resetBit <= 1'b0;
      end else if (tckRise && selReset && inShiftDr) begin
         resetBit <= tdiS;
      end
   end

   // boundary chain, cells per pin: input, data, control, pullup
   logic [CHAIN_LEN-1:0] bsShift;
   logic [CHAIN_LEN-1:0] bsLatch;
   logic [CHAIN_LEN-1:0] bsCapture;

   // loop over pins; chain samples the real pins and the drive on pinDrive
   always_comb begin
      bsCapture = '0;
      for (int p = 0; p < PIN_COUNT; p++) begin
         bsCapture[p*CELLS+CELL_IN]     = pinSyncB[p];
         bsCapture[p*CELLS+CELL_OUT]    = pinDrive.outData[p];
         bsCapture[p*CELLS+CELL_CTRL]   = pinDrive.outCtrl[p];
         bsCapture[p*CELLS+CELL_PULLUP] = pinDrive.pullupDisable[p];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         bsShift <= '0;
         bsLatch <= '0;
      end else if (tckRise && selChain) begin
         if (inCapDr) begin
            bsShift <= bsCapture;
         end else if (inShiftDr) begin
            bsShift <= {tdiS, bsShift[CHAIN_LEN-1:1]};
         end else if (inUpdDr) begin
            bsLatch <= bsShift;
         end
      end
   end

   // tdo moves on the falling tck edge so the controller samples stable data
   logic drOut;
   assign drOut = selChain ? bsShift[0] :
                  selId    ? idShift[0] :
                  selReset ? resetBit   : bypassBit;

   always_ff @(posedge clock) begin
      if (reset || !portEnabled) begin
         tdo       <= 1'b0;
         tdoEnable <= 1'b0;
      end else if (tckFall) begin
         tdo       <= inShiftIr ? irShift[0] : drOut;
         tdoEnable <= inShiftIr | inShiftDr;
      end
   end

   // chip reset and its time-out
   logic [TIMEOUT_WIDTH-1:0] timeoutCount;
   wire resetSource = resetBit | extResetS;
   wire [TIMEOUT_WIDTH-1:0] timeoutLoad = clockOptionFuse ?
      TIMEOUT_WIDTH'(TIMEOUT_LONG_CYCLES) : TIMEOUT_WIDTH'(TIMEOUT_SHORT_CYCLES);

   always_ff @(posedge clock) begin
      if (reset || resetSource) begin
         timeoutCount <= timeoutLoad;
      end else if (timeoutCount != '0) begin
         timeoutCount <= timeoutCount - 1'b1;
      end
   end

   assign chipReset = resetSource | (timeoutCount != '0);

   // pin drive: EXTEST drives latches, otherwise reset floats, otherwise core
   bst_pins_type latchPins;

   always_comb begin
      for (int p = 0; p < PIN_COUNT; p++) begin
         latchPins.outData[p]       = bsLatch[p*CELLS+CELL_OUT];
         latchPins.outCtrl[p]       = bsLatch[p*CELLS+CELL_CTRL];
         latchPins.pullupDisable[p] = bsLatch[p*CELLS+CELL_PULLUP];
      end
   end

   // feeding reset straight through means no cycle of stray drive
   always_comb begin
      if (chipReset && !selExtest) begin
         pinDrive = '{pullupDisable: '1, outCtrl: '0, outData: '0};
      end else if (selExtest) begin
         pinDrive = latchPins;
      end else begin
         pinDrive = corePins;
      end
   end

   // ahb-lite slave, zero wait states
   wire [31:0] statusValue = {9'h000, selExtest, chipReset, portEnabled,
                              instr, state};
   wire        addrPhase   = hsel & htrans[1] & hready;
   wire [7:0]  reqAddr     = haddr[7:0];
   wire [31:0] readValue   = (reqAddr == ADDR_CONTROL) ? {31'h0, disableBit} :
                             (reqAddr == ADDR_STATUS)  ? statusValue :
                             (reqAddr == ADDR_IDCODE)  ? idValue : 32'h0;

   always_ff @(posedge clock) begin
      if (reset) begin
         busWrite <= 1'b0;
         busAddr  <= 8'h00;
         hrdata   <= 32'h0;
      end else begin
         busWrite <= addrPhase & hwrite;
         if (addrPhase) begin
            busAddr <= reqAddr;
         end
         if (addrPhase && !hwrite) begin
            hrdata <= readValue;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         disableBit <= CTRL_DISABLE_RESET;
      end else if (busWrite && busAddr == ADDR_CONTROL) begin
         disableBit <= hwdata[CTRL_DISABLE_BIT];
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

endmodule : bst_tap

// >>> verif/bst_tap_chk.sv
`timescale 1ns/1ps
module bst_tap_chk
   import bst_pkg::*;
(
   // system and bus answer
   input wire logic         clock,
   input wire logic         reset,
   input wire logic         hreadyout,
   input wire logic         hresp,
   // test port and fuses
   input wire logic         tck,
   input wire logic         tdo,
   input wire logic         tdoEnable,
   input wire logic         testPortEnableFuse,
   input wire logic         clockOptionFuse,
   input wire logic         externalReset_n,
   // reset and pins
   input wire logic         chipReset,
   input wire bst_pins_type pinDrive
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // cycles since reset release, saturating
   int relCnt;
   always_ff @(posedge clock) begin
      if (reset) relCnt <= 0;
      else if (relCnt < 100) relCnt <= relCnt + 1;
   end
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   a_release_state: assert property ($fell(reset) |-> chipReset && !tdoEnable)
      else $error("state after reset release wrong");
   a_timeout_hold: assert property (relCnt < 38 |-> chipReset)
      else $error("chip reset dropped before time-out");
   a_timeout_end: assert property (relCnt == 60 && !clockOptionFuse |-> !chipReset)
      else $error("chip reset held past time-out");
   a_ext_reset: assert property (!externalReset_n [*4] |-> chipReset)
      else $error("external reset not followed");
   a_reset_float: assert property ($rose(chipReset) |-> pinDrive.outCtrl == 8'h00)
      else $error("pins driven on entering reset");
   a_fuse_gate: assert property (!testPortEnableFuse [*6] |-> !tdoEnable)
      else $error("tdo driven with port fuse clear");
   a_tdo_on_low: assert property ($changed(tdo) || $changed(tdoEnable) |-> !tck)
      else $error("tdo moved while tck high");
   cover property ($fell(chipReset));
   cover property ($rose(tdoEnable));
   cover property (pinDrive.outCtrl == 8'hF0);
endmodule : bst_tap_chk

bind bst_tap bst_tap_chk u_bst_tap_chk (.clock(clock), .reset(reset), .hreadyout(hreadyout),
   .hresp(hresp), .tck(tck), .tdo(tdo), .tdoEnable(tdoEnable),
   .testPortEnableFuse(testPortEnableFuse), .clockOptionFuse(clockOptionFuse),
   .externalReset_n(externalReset_n), .chipReset(chipReset), .pinDrive(pinDrive));

// >>> verif/bst_tap_master.sv
`timescale 1ns/1ps
module bst_tap_master (
   // controller side of the test port
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   logic seen;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // one tck period, off the system clock grid; tck parks low between frames
   task step(input logic m, input logic d);
      tms = m;
      tdi = d;
      #87 tck = 1'b1;
      seen = tdo;
      #100 tck = 1'b0;
      #13;
   endtask : step
   task tlr;
      repeat (5) step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask : tlr
   // starts and ends in idle
   task scan(input logic ir, input int n, input logic [31:0] d, output logic [31:0] o);
      o = 32'h0;
      step(1'b1, 1'b0);
      if (ir) step(1'b1, 1'b0);
      step(1'b0, 1'b0);
      step(1'b0, 1'b0);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, d[i]);
         o[i] = seen;
      end
      step(1'b1, ~d[n-1]);
      step(1'b0, d[n-1]);
      // released data line shows no stale level
      tdi = ~tdi;
   endtask : scan
endmodule : bst_tap_master

// >>> verif/bst_tap_tb.sv
`timescale 1ns/1ps
module bst_tap_tb
   import bst_pkg::*;
;
   logic         clock = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0]   htrans = 2'h0;
   logic [31:0]  haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic         hreadyout, hresp, tck, tms, tdi, tdo, tdoEnable, chipReset;
   logic         fuse = 1'b1, extRst_n = 1'b1, optFuse = 1'b0;
   logic [7:0]   pinIn = 8'h00;
   bst_pins_type pinDrive, corePins = 24'hFF0FA5;
   logic [3:0]   codes [3] = '{INSTR_BYPASS, 4'h8, 4'h3};
   logic [31:0]  idVal = {ID_VERSION, ID_PART_NUMBER, ID_MANUFACTURER, 1'b1};
   int           err_count = 0, n_compared = 0;

   bst_tap u_bst_tap (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tck(tck), .tms(tms),
      .tdi(tdi), .tdo(tdo), .tdoEnable(tdoEnable), .testPortEnableFuse(fuse),
      .clockOptionFuse(optFuse), .externalReset_n(extRst_n), .corePins(corePins),
      .chipReset(chipReset), .pinIn(pinIn), .pinDrive(pinDrive));
   bst_tap_master u_bst_tap_master (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

   always #12.5 clock = ~clock;

   task report_and_stop;
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wt;
      int i;
      for (i = 0; i < 20; i++) begin
         @(posedge clock);
         if (hreadyout === 1'b1) break;
      end
      if (i == 20) begin
         err_count++;
         report_and_stop();
      end
   endtask : wt
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      wt();
      htrans <= 2'h0;
      hwdata <= d;
      wt();
      q = hrdata;
   endtask : ahb
   task rd(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rd
   task sc(input logic ir, input int n, input logic [31:0] d, input logic [31:0] e);
      u_bst_tap_master.scan(ir, n, d, q);
      chk(q, e);
   endtask : sc
   task mv(input logic m);
      u_bst_tap_master.step(m, 1'b0);
   endtask : mv
   // status word: flags are {extest, chip reset, enabled}
   function automatic logic [31:0] sv(logic [15:0] s, logic [3:0] i, logic [2:0] f);
      return {9'h0, f, i, s};
   endfunction : sv
   // boundary chain image, four cells per pin
   function automatic logic [31:0] chn(logic [7:0] i, logic [7:0] d, logic [7:0] c,
                                       logic [7:0] u);
      logic [31:0] r;
      for (int p = 0; p < 8; p++) r[p*4 +: 4] = {u[p], c[p], d[p], i[p]};
      return r;
   endfunction : chn

   initial begin
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      repeat (4) @(posedge clock);
      rd(ADDR_STATUS, sv(16'h0001, INSTR_IDCODE, 3'b011));
      rd(ADDR_IDCODE, idVal);
      rd(8'h0C, 32'h0);
      repeat (50) @(posedge clock);
      chk(chipReset, 1'b0);
      u_bst_tap_master.tlr();
      sc(1'b0, 32, 32'h0, idVal);
      foreach (codes[k]) begin
         sc(1'b1, 4, codes[k], 32'h1);
         sc(1'b0, 8, 32'hB5, 32'h6A);
         chk(tdoEnable, 1'b0);
      end
      @(posedge clock);
      pinIn <= 8'h5A;
      sc(1'b1, 4, INSTR_SAMPLE, 32'h1);
      sc(1'b0, 32, chn(0, 8'h3C, 8'hFF, 0), chn(8'h5A, 8'hA5, 8'h0F, 8'hFF));
      chk(pinDrive, corePins);
      sc(1'b1, 4, INSTR_EXTEST, 32'h1);
      chk(pinDrive, 24'h00FF3C);
      sc(1'b0, 32, chn(0, 8'hC3, 8'hF0, 8'h0F), chn(8'h5A, 8'h3C, 8'hFF, 0));
      chk(pinDrive, 24'h0FF0C3);
      sc(1'b1, 4, INSTR_CHIP_RESET, 32'h1);
      sc(1'b0, 1, 32'h1, 32'h0);
      chk(pinDrive.outCtrl, 8'h00);
      rd(ADDR_STATUS, sv(16'h0002, INSTR_CHIP_RESET, 3'b011));
      sc(1'b0, 1, 32'h0, 32'h1);
      chk(chipReset, 1'b1);
      repeat (50) @(posedge clock);
      chk(chipReset, 1'b0);
      ahb(1'b1, ADDR_CONTROL, 32'h1);
      rd(ADDR_CONTROL, 32'h1);
      repeat (4) @(posedge clock);
      rd(ADDR_STATUS, sv(16'h0001, INSTR_IDCODE, 3'b000));
      ahb(1'b1, ADDR_CONTROL, 32'h0);
      @(posedge clock);
      fuse <= 1'b0;
      repeat (8) @(posedge clock);
      rd(ADDR_STATUS, sv(16'h0001, INSTR_IDCODE, 3'b000));
      fuse <= 1'b1;
      repeat (8) @(posedge clock);
      u_bst_tap_master.tlr();
      sc(1'b1, 4, INSTR_BYPASS, 32'h1);
      mv(1'b1);
      mv(1'b0);
      mv(1'b0);
      u_bst_tap_master.tlr();
      rd(ADDR_STATUS, sv(16'h0002, INSTR_IDCODE, 3'b001));
      @(posedge clock);
      extRst_n <= 1'b0;
      repeat (6) @(posedge clock);
      chk(chipReset, 1'b1);
      chk(pinDrive.outCtrl, 8'h00);
      // long time-out option, chosen while reset still holds the counter
      optFuse  <= 1'b1;
      extRst_n <= 1'b1;
      repeat (2500) @(posedge clock);
      chk(chipReset, 1'b1);
      repeat (100) @(posedge clock);
      chk(chipReset, 1'b0);
      report_and_stop();
   end
endmodule : bst_tap_tb
